// ==== cis_pkg.sv ====
// Constants and state types for the channel interrupt status block.
package cis_pkg;

	////////////////////////////////////////////////////////////////////////////
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int LVL_W  = 5;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets on the plain register port.
	localparam logic [ADDR_W-1:0] OFS_FLAGS    = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CLEAR    = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_ENABLE   = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_EDGE_SEL = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_LEVELS   = 4'h4;

	////////////////////////////////////////////////////////////////////////////
	// Flag positions in channel_interrupt_flags_0.
	localparam int FLG_AMP   = 7;
	localparam int FLG_TXJ   = 6;
	localparam int FLG_RXJ   = 5;
	localparam int FLG_TOC   = 4;
	localparam int FLG_TCK   = 3;
	localparam int FLG_TLOS  = 2;
	localparam int FLG_SLOS  = 1;
	localparam int FLG_LLOS  = 0;

	// Level positions in channel_status_word_0.
	localparam int LVL_LLOS  = 0;
	localparam int LVL_SLOS  = 1;
	localparam int LVL_TLOS  = 2;
	localparam int LVL_TCK   = 3;
	localparam int LVL_TOC   = 4;

	// Edge-select positions in interrupt_edge_select_word.
	localparam int ES_LOS    = 1;
	localparam int ES_TLOS   = 2;
	localparam int ES_TCK    = 3;
	localparam int ES_TOC    = 4;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and writable masks.
	localparam logic [DATA_W-1:0] RST_FLAGS    = 8'h00;
	localparam logic [DATA_W-1:0] RST_ENABLE   = 8'h00;
	localparam logic [DATA_W-1:0] RST_EDGE_SEL = 8'h00;
	localparam logic [DATA_W-1:0] RST_RDATA    = 8'h00;
	localparam logic [DATA_W-1:0] MASK_EDGE    = 8'h1E;
	localparam logic [LVL_W-1:0]  RST_LVL      = 5'h00;

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic stable;
		logic prev;
	} cis_sync_s;

	typedef struct packed {
		logic [DATA_W-1:0] flags;
		logic [DATA_W-1:0] enable;
		logic [DATA_W-1:0] edge_sel;
		logic [DATA_W-1:0] rdata;
		logic              irq;
	} cis_state_s;

endpackage

// ==== cis_edge_sync.sv ====
// Three-stage synchroniser and stable-level tracker for the status levels.
`timescale 1ns/1ps
module cis_edge_sync
	import cis_pkg::*;
(
	input  wire logic             SYS_CLK,
	input  wire logic             RSTN,
	input  wire logic [LVL_W-1:0] LEVEL_IN,
	output logic      [LVL_W-1:0] LEVEL,
	output logic      [LVL_W-1:0] PREV
);

	////////////////////////////////////////////////////////////////////////////
	genvar lane;
	generate
		for (lane = 0; lane < LVL_W; lane++) begin : g_lane
			cis_sync_s st_q;
			cis_sync_s st_d;

			// A change counts only once the second and third stages agree, so a
			// level caught mid-transition by the first stage never reaches the flags.
			always_comb begin
				st_d        = st_q;
				st_d.s1     = LEVEL_IN[lane];
				st_d.s2     = st_q.s1;
				st_d.s3     = st_q.s2;
				st_d.prev   = st_q.stable;
				if (st_q.s2 == st_q.s3) begin
					st_d.stable = st_q.s3;
				end
			end

			always_ff @(posedge SYS_CLK or negedge RSTN) begin
				if (!RSTN) begin
					st_q <= '0;
				end else begin
					st_q <= st_d;
				end
			end

			assign LEVEL[lane] = st_q.stable;
			assign PREV[lane]  = st_q.prev;
		end
	endgenerate

endmodule

// ==== cis_int_status.sv ====
// Channel interrupt status flags with edge selection, enables and interrupt output.
//
// Contract
// - Amplitude overflow sets flag bit 7, which is reported on the interrupt output.
// - Transmit jitter FIFO error sets bit 6, receive jitter FIFO error sets bit 5.
// - Flags are sticky; writing one clears a flag, writing zero leaves it.
// - After reset every flag reads zero.
// - Edge select bit 1 low: line loss flag sets on rising line loss level only.
// - Edge select bit 1 high: line loss flag sets on any line loss change.
// - System loss flag follows system loss level, rising or either edge per select.
// - Output condition flag follows its level, rising or either edge per its select.
// - Missing clock flag follows its level, rising or either edge per its select.
// - Interrupt output is active while any enabled flag is set.
`timescale 1ns/1ps
module cis_int_status
	import cis_pkg::*;
(
	input  wire logic              SYS_CLK,
	input  wire logic              RSTN,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [DATA_W-1:0] WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [DATA_W-1:0] RDATA,
	input  wire logic              AMPLITUDE_OVERFLOW_EVENT,
	input  wire logic              TX_JITTER_FIFO_EVENT,
	input  wire logic              RX_JITTER_FIFO_EVENT,
	input  wire logic              LINE_SIGNAL_LOSS_LEVEL,
	input  wire logic              SYSTEM_SIGNAL_LOSS_LEVEL,
	input  wire logic              TX_SIGNAL_LOSS_LEVEL,
	input  wire logic              TX_CLOCK_MISSING_LEVEL,
	input  wire logic              TX_OUTPUT_CONDITION_LEVEL,
	output logic                   IRQ
);

	////////////////////////////////////////////////////////////////////////////
	// Synchronised levels.

	logic [LVL_W-1:0] level_pins;
	logic [LVL_W-1:0] lvl;
	logic [LVL_W-1:0] lvl_prev;

	always_comb begin
		level_pins           = RST_LVL;
		level_pins[LVL_LLOS] = LINE_SIGNAL_LOSS_LEVEL;
		level_pins[LVL_SLOS] = SYSTEM_SIGNAL_LOSS_LEVEL;
		level_pins[LVL_TLOS] = TX_SIGNAL_LOSS_LEVEL;
		level_pins[LVL_TCK]  = TX_CLOCK_MISSING_LEVEL;
		level_pins[LVL_TOC]  = TX_OUTPUT_CONDITION_LEVEL;
	end

	cis_edge_sync u_sync (
		.SYS_CLK  (SYS_CLK),
		.RSTN     (RSTN),
		.LEVEL_IN (level_pins),
		.LEVEL    (lvl),
		.PREV     (lvl_prev)
	);

	////////////////////////////////////////////////////////////////////////////
	// Edge qualification.

	logic [LVL_W-1:0] rise;
	logic [LVL_W-1:0] fall;

	assign rise = lvl & ~lvl_prev;
	assign fall = ~lvl & lvl_prev;

	////////////////////////////////////////////////////////////////////////////
	// State.

	cis_state_s st_q;
	cis_state_s st_d;

	logic [DATA_W-1:0] set_w;
	logic [DATA_W-1:0] clr_w;
	logic              wr_flags;

	// Both the flag word and the clear word accept write-one-to-clear.
	assign wr_flags = WR && ((ADDR == OFS_FLAGS) || (ADDR == OFS_CLEAR));
	assign clr_w    = wr_flags ? WDATA : RST_FLAGS;

	always_comb begin
		set_w           = RST_FLAGS;
		set_w[FLG_AMP]  = AMPLITUDE_OVERFLOW_EVENT;
		set_w[FLG_TXJ]  = TX_JITTER_FIFO_EVENT;
		set_w[FLG_RXJ]  = RX_JITTER_FIFO_EVENT;
		set_w[FLG_LLOS] = rise[LVL_LLOS]
			| (fall[LVL_LLOS] & st_q.edge_sel[ES_LOS]);
		set_w[FLG_SLOS] = rise[LVL_SLOS]
			| (fall[LVL_SLOS] & st_q.edge_sel[ES_LOS]);
		set_w[FLG_TLOS] = rise[LVL_TLOS]
			| (fall[LVL_TLOS] & st_q.edge_sel[ES_TLOS]);
		set_w[FLG_TCK]  = rise[LVL_TCK]
			| (fall[LVL_TCK] & st_q.edge_sel[ES_TCK]);
		set_w[FLG_TOC]  = rise[LVL_TOC]
			| (fall[LVL_TOC] & st_q.edge_sel[ES_TOC]);
	end

	always_comb begin
		st_d = st_q;

		// A flag event in the same cycle as its clear wins, so no event is lost.
		st_d.flags = (st_q.flags & ~clr_w) | set_w;

		if (WR) begin
			if (ADDR == OFS_ENABLE) begin
				st_d.enable = WDATA;
			end else if (ADDR == OFS_EDGE_SEL) begin
				st_d.edge_sel = WDATA & MASK_EDGE;
			end
		end

		// Read data stand for exactly one cycle; unmapped and write-only words read zero.
		st_d.rdata = RST_RDATA;
		if (RD) begin
			if (ADDR == OFS_FLAGS) begin
				st_d.rdata = st_q.flags;
			end else if (ADDR == OFS_ENABLE) begin
				st_d.rdata = st_q.enable;
			end else if (ADDR == OFS_EDGE_SEL) begin
				st_d.rdata = st_q.edge_sel;
			end else if (ADDR == OFS_LEVELS) begin
				st_d.rdata = {{(DATA_W-LVL_W){1'b0}}, lvl};
			end else begin
				st_d.rdata = RST_RDATA;
			end
		end

		// Registered from next values so the pin follows the flags with no extra lag.
		st_d.irq = |(st_d.flags & st_d.enable);
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_q.flags    <= RST_FLAGS;
			st_q.enable   <= RST_ENABLE;
			st_q.edge_sel <= RST_EDGE_SEL;
			st_q.rdata    <= RST_RDATA;
			st_q.irq      <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign RDATA = st_q.rdata;
	assign IRQ   = st_q.irq;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	chk_amp_sets: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		AMPLITUDE_OVERFLOW_EVENT |=> st_q.flags[FLG_AMP]
	) else $error("Amplitude overflow did not set its flag.");

	chk_txj_sets: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		TX_JITTER_FIFO_EVENT |=> st_q.flags[FLG_TXJ]
	) else $error("Transmit jitter FIFO event did not set its flag.");

	chk_rxj_sets: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		RX_JITTER_FIFO_EVENT |=> st_q.flags[FLG_RXJ]
	) else $error("Receive jitter FIFO event did not set its flag.");

	chk_flags_sticky: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		1'b1 |=> ((($past(st_q.flags) & ~$past(clr_w)) & ~st_q.flags) == RST_FLAGS)
	) else $error("A flag dropped without a one being written.");

	chk_clear_one: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(wr_flags && WDATA[FLG_AMP] && !AMPLITUDE_OVERFLOW_EVENT) |=> !st_q.flags[FLG_AMP]
	) else $error("Writing one did not clear the amplitude flag.");

	chk_reset_zero: assert property (
		@(posedge SYS_CLK)
		$rose(RSTN) |-> (st_q.flags == RST_FLAGS)
	) else $error("Flags not zero after reset.");

	chk_llos_rise: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(!lvl_prev[LVL_LLOS] && lvl[LVL_LLOS]) |=> st_q.flags[FLG_LLOS]
	) else $error("Line loss rise did not set its flag.");

	chk_llos_no_fall: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(fall[LVL_LLOS] && !st_q.edge_sel[ES_LOS] && !st_q.flags[FLG_LLOS])
			|=> !st_q.flags[FLG_LLOS]
	) else $error("Line loss fall set its flag in rising-only mode.");

	chk_llos_any: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(fall[LVL_LLOS] && st_q.edge_sel[ES_LOS]) |=> st_q.flags[FLG_LLOS]
	) else $error("Line loss fall missed in any-edge mode.");

	chk_slos_edge: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(rise[LVL_SLOS] || (fall[LVL_SLOS] && st_q.edge_sel[ES_LOS])) |=> st_q.flags[FLG_SLOS]
	) else $error("System loss edge did not set its flag.");

	chk_toc_edge: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(rise[LVL_TOC] || (fall[LVL_TOC] && st_q.edge_sel[ES_TOC])) |=> st_q.flags[FLG_TOC]
	) else $error("Output condition edge did not set its flag.");

	chk_tck_edge: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(rise[LVL_TCK] || (fall[LVL_TCK] && st_q.edge_sel[ES_TCK])) |=> st_q.flags[FLG_TCK]
	) else $error("Missing clock edge did not set its flag.");

	chk_tlos_edge: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(rise[LVL_TLOS] || (fall[LVL_TLOS] && st_q.edge_sel[ES_TLOS])) |=> st_q.flags[FLG_TLOS]
	) else $error("Transmit loss edge did not set its flag.");

	chk_irq_level: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		IRQ == (|(st_q.flags & st_q.enable))
	) else $error("Interrupt output disagrees with enabled flags.");

	chk_flags_read: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(RD && ADDR == OFS_FLAGS) |=> (RDATA == $past(st_q.flags))
	) else $error("Flag read returned wrong data.");

	chk_clear_all: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		wr_flags |=> ((st_q.flags & $past(WDATA) & ~$past(set_w)) == RST_FLAGS)
	) else $error("A written one left its flag set with no new event.");

	chk_zero_keeps: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(wr_flags && !WDATA[FLG_LLOS] && st_q.flags[FLG_LLOS]) |=> st_q.flags[FLG_LLOS]
	) else $error("Writing zero cleared the line loss flag.");

	chk_flags_quiet: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		((rise == RST_LVL) && (fall == RST_LVL) && !AMPLITUDE_OVERFLOW_EVENT && !TX_JITTER_FIFO_EVENT
			&& !RX_JITTER_FIFO_EVENT && !wr_flags) |=> $stable(st_q.flags)
	) else $error("Flags changed with no event and no clear.");

	chk_enable_write: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(WR && (ADDR == OFS_ENABLE)) |=> (st_q.enable == $past(WDATA))
	) else $error("Enable write did not land.");

	chk_enable_hold: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		!(WR && (ADDR == OFS_ENABLE)) |=> $stable(st_q.enable)
	) else $error("Enable word changed without a write.");

	chk_edge_write: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(WR && (ADDR == OFS_EDGE_SEL)) |=> (st_q.edge_sel == ($past(WDATA) & MASK_EDGE))
	) else $error("Edge select write did not land.");

	chk_edge_hold: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		!(WR && (ADDR == OFS_EDGE_SEL)) |=> $stable(st_q.edge_sel)
	) else $error("Edge select changed without a write.");

	chk_edge_masked: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(st_q.edge_sel & ~MASK_EDGE) == RST_EDGE_SEL
	) else $error("Unused edge select bits are set.");

	chk_rdata_idle: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		!RD |=> (RDATA == RST_RDATA)
	) else $error("Read data stood without a read.");

	chk_enable_read: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(RD && (ADDR == OFS_ENABLE)) |=> (RDATA == $past(st_q.enable))
	) else $error("Enable read returned wrong data.");

	chk_edge_read: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(RD && (ADDR == OFS_EDGE_SEL)) |=> (RDATA == $past(st_q.edge_sel))
	) else $error("Edge select read returned wrong data.");

	chk_level_read: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(RD && (ADDR == OFS_LEVELS)) |=> (RDATA == {{(DATA_W-LVL_W){1'b0}}, $past(lvl)})
	) else $error("Level read returned wrong data.");

	chk_clear_unread: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(RD && (ADDR == OFS_CLEAR)) |=> (RDATA == RST_RDATA)
	) else $error("Clear word did not read zero.");

	chk_slos_no_fall: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(fall[LVL_SLOS] && !st_q.edge_sel[ES_LOS] && !st_q.flags[FLG_SLOS]) |=> !st_q.flags[FLG_SLOS]
	) else $error("System loss fall set its flag in rising-only mode.");

	chk_tlos_no_fall: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(fall[LVL_TLOS] && !st_q.edge_sel[ES_TLOS] && !st_q.flags[FLG_TLOS]) |=> !st_q.flags[FLG_TLOS]
	) else $error("Transmit loss fall set its flag in rising-only mode.");

	chk_tck_no_fall: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(fall[LVL_TCK] && !st_q.edge_sel[ES_TCK] && !st_q.flags[FLG_TCK]) |=> !st_q.flags[FLG_TCK]
	) else $error("Missing clock fall set its flag in rising-only mode.");

	chk_toc_no_fall: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(fall[LVL_TOC] && !st_q.edge_sel[ES_TOC] && !st_q.flags[FLG_TOC]) |=> !st_q.flags[FLG_TOC]
	) else $error("Output condition fall set its flag in rising-only mode.");

	chk_irq_amp: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(st_q.flags[FLG_AMP] && st_q.enable[FLG_AMP]) |-> IRQ
	) else $error("Enabled amplitude flag did not raise the interrupt.");

	chk_irq_txj: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(st_q.flags[FLG_TXJ] && st_q.enable[FLG_TXJ]) |-> IRQ
	) else $error("Enabled transmit jitter flag did not raise the interrupt.");

	chk_irq_rxj: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(st_q.flags[FLG_RXJ] && st_q.enable[FLG_RXJ]) |-> IRQ
	) else $error("Enabled receive jitter flag did not raise the interrupt.");

	chk_irq_los: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(st_q.flags[FLG_LLOS] && st_q.enable[FLG_LLOS]) |-> IRQ
	) else $error("Enabled line loss flag did not raise the interrupt.");

	chk_irq_masked: assert property (
		@(posedge SYS_CLK) disable iff (!RSTN)
		(st_q.enable == RST_ENABLE) |-> !IRQ
	) else $error("Interrupt raised with every flag disabled.");

	chk_reset_regs: assert property (
		@(posedge SYS_CLK)
		$rose(RSTN) |-> ((st_q.enable == RST_ENABLE) && (st_q.edge_sel == RST_EDGE_SEL))
	) else $error("Enable or edge select not zero after reset.");

	chk_reset_outputs: assert property (
		@(posedge SYS_CLK)
		$rose(RSTN) |-> (!IRQ && (RDATA == RST_RDATA))
	) else $error("Outputs not idle after reset.");

endmodule

// ==== test_cis_int_status.sv ====
// Self-checking testbench for the channel interrupt status block.
`timescale 1ns/1ps
module test_cis_int_status
	import cis_pkg::*;
;
	logic              sys_clk = 1'b0;
	logic              rstn    = 1'b0;
	logic [ADDR_W-1:0] addr    = 4'h0;
	logic [DATA_W-1:0] wdata   = 8'h00;
	logic              wr      = 1'b0;
	logic              rd      = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic              amp     = 1'b0;
	logic              txj     = 1'b0;
	logic              rxj     = 1'b0;
	logic [LVL_W-1:0]  lvl     = 5'h00;
	logic              irq;
	int                err_count   = 0;
	int                comparisons = 0;
	int                es_pos [LVL_W] = '{ES_LOS, ES_LOS, ES_TLOS, ES_TCK, ES_TOC};

	always #50 sys_clk = ~sys_clk;

	cis_int_status u_cis_int_status (
		.SYS_CLK                   (sys_clk),
		.RSTN                      (rstn),
		.ADDR                      (addr),
		.WDATA                     (wdata),
		.WR                        (wr),
		.RD                        (rd),
		.RDATA                     (rdata),
		.AMPLITUDE_OVERFLOW_EVENT  (amp),
		.TX_JITTER_FIFO_EVENT      (txj),
		.RX_JITTER_FIFO_EVENT      (rxj),
		.LINE_SIGNAL_LOSS_LEVEL    (lvl[LVL_LLOS]),
		.SYSTEM_SIGNAL_LOSS_LEVEL  (lvl[LVL_SLOS]),
		.TX_SIGNAL_LOSS_LEVEL      (lvl[LVL_TLOS]),
		.TX_CLOCK_MISSING_LEVEL    (lvl[LVL_TCK]),
		.TX_OUTPUT_CONDITION_LEVEL (lvl[LVL_TOC]),
		.IRQ                       (irq)
	);

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR time=%0t expected=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge sys_clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd   <= 1'b0;
		#1;
		chk(exp, rdata);
	endtask

	task automatic irq_chk(input logic exp);
		#1;
		chk({7'h00, exp}, {7'h00, irq});
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic test_reset;
		rd_chk(OFS_FLAGS, RST_FLAGS);
		rd_chk(OFS_ENABLE, RST_ENABLE);
		rd_chk(OFS_EDGE_SEL, RST_EDGE_SEL);
		irq_chk(1'b0);
		wr_reg(OFS_EDGE_SEL, 8'hFF);
		rd_chk(OFS_EDGE_SEL, MASK_EDGE);
		wr_reg(OFS_EDGE_SEL, 8'h00);
		rd_chk(4'hF, 8'h00);
		rd_chk(OFS_CLEAR, 8'h00);
	endtask

	// Events set sticky flags; the interrupt follows only enabled flags.
	task automatic test_events;
		@(posedge sys_clk);
		amp <= 1'b1;
		txj <= 1'b1;
		rxj <= 1'b1;
		@(posedge sys_clk);
		amp <= 1'b0;
		txj <= 1'b0;
		rxj <= 1'b0;
		irq_chk(1'b0);
		rd_chk(OFS_FLAGS, 8'hE0);
		wr_reg(OFS_ENABLE, 8'h80);
		irq_chk(1'b1);
		wr_reg(OFS_FLAGS, 8'h00);
		rd_chk(OFS_FLAGS, 8'hE0);
		wr_reg(OFS_CLEAR, 8'h80);
		irq_chk(1'b0);
		rd_chk(OFS_FLAGS, 8'h60);
		wr_reg(OFS_ENABLE, 8'h20);
		irq_chk(1'b1);
		wr_reg(4'hF, 8'h00);
		rd_chk(OFS_ENABLE, 8'h20);
		wr_reg(OFS_FLAGS, 8'h60);
		irq_chk(1'b0);
		rd_chk(OFS_FLAGS, 8'h00);
	endtask

	// Each level is walked through rise and fall with rising-only and any-edge selection.
	task automatic test_levels;
		logic [DATA_W-1:0] f;
		logic [DATA_W-1:0] e;
		for (int i = 0; i < LVL_W; i++) begin
			f = 8'h01 << i;
			e = 8'h01 << es_pos[i];
			wr_reg(OFS_EDGE_SEL, 8'h00);
			wr_reg(OFS_ENABLE, f);
			@(posedge sys_clk);
			lvl[i] <= 1'b1;
			wait_cyc(8);
			rd_chk(OFS_LEVELS, f);
			rd_chk(OFS_FLAGS, f);
			irq_chk(1'b1);
			wr_reg(OFS_FLAGS, f);
			lvl[i] <= 1'b0;
			wait_cyc(8);
			rd_chk(OFS_FLAGS, 8'h00);
			wr_reg(OFS_EDGE_SEL, e);
			lvl[i] <= 1'b1;
			wait_cyc(8);
			rd_chk(OFS_FLAGS, f);
			wr_reg(OFS_CLEAR, f);
			lvl[i] <= 1'b0;
			wait_cyc(8);
			rd_chk(OFS_FLAGS, f);
			wr_reg(OFS_CLEAR, f);
			rd_chk(OFS_FLAGS, 8'h00);
		end
	endtask

	// A clear that meets a new event in the same cycle must not lose the event.
	task automatic test_set_wins;
		@(posedge sys_clk);
		amp   <= 1'b1;
		@(posedge sys_clk);
		wr    <= 1'b1;
		addr  <= OFS_CLEAR;
		wdata <= 8'h80;
		@(posedge sys_clk);
		wr    <= 1'b0;
		amp   <= 1'b0;
		rd_chk(OFS_FLAGS, 8'h80);
		wr_reg(OFS_CLEAR, 8'h80);
		rd_chk(OFS_FLAGS, 8'h00);
		@(posedge sys_clk);
		#1;
		chk(RST_RDATA, rdata);
	endtask

	// A reset in mid-run must drop every flag, enable and select, and the interrupt with them.
	task automatic test_mid_reset;
		wr_reg(OFS_ENABLE, 8'hFF);
		wr_reg(OFS_EDGE_SEL, MASK_EDGE);
		@(posedge sys_clk);
		amp <= 1'b1;
		@(posedge sys_clk);
		amp <= 1'b0;
		irq_chk(1'b1);
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		irq_chk(1'b0);
		@(posedge sys_clk);
		rstn <= 1'b1;
		rd_chk(OFS_FLAGS, RST_FLAGS);
		rd_chk(OFS_ENABLE, RST_ENABLE);
		rd_chk(OFS_EDGE_SEL, RST_EDGE_SEL);
		irq_chk(1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// The whole sequence needs well under a thousand cycles; five thousand is ample.
	initial begin
		#500000;
		err_count++;
		end_sim();
	end

	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		test_reset();
		test_events();
		test_set_wins();
		test_levels();
		test_mid_reset();
		end_sim();
	end

endmodule
